/* File: comparator_control_pkg.sv */
// Constants for the comparator control and output latch block.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package comparator_control_pkg;
   localparam int num_comparators = 4;
   localparam int num_latched = 3;
   localparam logic [3:0] addr_enable_hysteresis = 4'h0;
   localparam logic [3:0] addr_latch_input_select = 4'h4;
   localparam int hyst_lsb = 4;
   localparam int on_lsb = 0;
   localparam int switch_bit = 1;
   localparam int src_ch1_lsb = 2;
   localparam logic [7:0] reset_enable_hysteresis = 8'hf0;
   localparam logic [7:0] reset_latch_input_select = 8'h00;
   localparam logic [7:0] mask_latch_input_select = 8'hfe;
   localparam logic [1:0] src_direct = 2'h0;
   localparam logic [1:0] src_pwm = 2'h1;
   localparam logic [1:0] src_high_gates = 2'h2;
   localparam logic [1:0] src_low_gates = 2'h3;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
endpackage : comparator_control_pkg

/* File: comparator_output_latch.sv */
// One comparator output latch with its source selection.
// Assumes comparator, PWM and gate inputs are already synchronised to aclk.
module comparator_output_latch (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Controls
   input wire logic [1:0] latch_source,
   input wire logic pwm_out,
   input wire logic high_gates_or,
   input wire logic low_gates_or,
   // Data
   input wire logic comp_in,
   output logic comp_out
);
   typedef struct packed {
      logic held;
   } latch_state_t;

   latch_state_t state;
   latch_state_t next_state;
   logic gate;

   always_comb begin
      case (latch_source)
         comparator_control_pkg::src_pwm: gate = pwm_out;
         comparator_control_pkg::src_high_gates: gate = high_gates_or;
         comparator_control_pkg::src_low_gates: gate = low_gates_or;
         default: gate = 1'b1;
      endcase
   end

   // Transparent while the gate is high, holds while low
   always_comb begin
      next_state = state;
      if (gate) begin
         next_state.held = comp_in;
      end
      comp_out = (latch_source == comparator_control_pkg::src_direct) ? comp_in :
                 (gate ? comp_in : state.held);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule : comparator_output_latch

/* File: comparator_control_latch.sv */
// Comparator enable, hysteresis, negative input routing and output latch control.
// Assumes an AXI4-Lite master on aclk; comparator and gate inputs come from other domains.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.

module comparator_control_latch #(
   parameter int num_comparators = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Raw comparator outputs from the analog cores
   input wire logic [3:0] comparator_raw,
   // PWM and gate signals
   input wire logic pwm_out_ch0,
   input wire logic pwm_out_ch1,
   input wire logic pwm_out_ch2,
   input wire logic phase_a_high_gate,
   input wire logic phase_b_high_gate,
   input wire logic phase_c_high_gate,
   input wire logic phase_a_low_gate,
   input wire logic phase_b_low_gate,
   input wire logic phase_c_low_gate,
   // Analog controls
   output logic [3:0] comparator_on,
   output logic [3:0] hysteresis_enable,
   output logic [3:0] pull_high_disconnect,
   output logic [2:0] negative_pin_select_own,
   output logic shared_negative_pin_select,
   // Conditioned comparator outputs
   output logic [3:0] comparator_out
);
   typedef struct packed {
      logic [1:0][3:0] sync_raw;
      logic [1:0][8:0] sync_gates;
      logic [7:0] comparator_enable_hysteresis;
      logic [7:0] comparator_latch_input_select;
      logic aw_held;
      logic [3:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] comp_on;
      logic [3:0] hyst;
      logic [3:0] pull_off;
      logic [2:0] neg_own;
      logic neg_shared;
      logic [3:0] comp_out;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;
   logic [2:0] latched_out;
   logic high_or;
   logic low_or;
   logic [2:0] pwm_sync;

   function automatic logic addr_is_mapped(input logic [3:0] addr);
      addr_is_mapped = (addr == comparator_control_pkg::addr_enable_hysteresis) ||
                       (addr == comparator_control_pkg::addr_latch_input_select);
   endfunction : addr_is_mapped

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      merge_byte = strb[0] ? data[7:0] : old;
   endfunction : merge_byte

   assign high_or = state.sync_gates[1][3] | state.sync_gates[1][4] | state.sync_gates[1][5];
   assign low_or = state.sync_gates[1][6] | state.sync_gates[1][7] | state.sync_gates[1][8];
   assign pwm_sync = state.sync_gates[1][2:0];

   // Latches for channels 1 to 3; channel 0 passes directly
   genvar ch;
   generate
      for (ch = 1; ch <= comparator_control_pkg::num_latched; ch++) begin : g_latch
         comparator_output_latch u_latch (
            .aclk(aclk),
            .aresetn(aresetn),
            .latch_source(state.comparator_latch_input_select[comparator_control_pkg::src_ch1_lsb
                          + 2 * (ch - 1) +: 2]),
            .pwm_out(pwm_sync[ch - 1]),
            .high_gates_or(high_or),
            .low_gates_or(low_or),
            .comp_in(state.sync_raw[1][ch]),
            .comp_out(latched_out[ch - 1])
         );
      end
   endgenerate

   always_comb begin
      logic [7:0] cfg;
      logic do_write;
      cfg = 8'h00;
      do_write = 1'b0;
      next_state = state;
      next_state.sync_raw[0] = comparator_raw;
      next_state.sync_raw[1] = state.sync_raw[0];
      next_state.sync_gates[0] = {phase_c_low_gate, phase_b_low_gate, phase_a_low_gate,
                                  phase_c_high_gate, phase_b_high_gate, phase_a_high_gate,
                                  pwm_out_ch2, pwm_out_ch1, pwm_out_ch0};
      next_state.sync_gates[1] = state.sync_gates[0];

      // Write channel: address and data accepted in either order
      if (s_axi_awvalid && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      if (state.aw_held && state.w_held && !state.bvalid) begin
         do_write = 1'b1;
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = addr_is_mapped(state.aw_addr) ? comparator_control_pkg::resp_okay :
                            comparator_control_pkg::resp_slverr;
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      if (do_write) begin
         if (state.aw_addr == comparator_control_pkg::addr_enable_hysteresis) begin
            next_state.comparator_enable_hysteresis = merge_byte(state.comparator_enable_hysteresis,
                                                                 state.w_data, state.w_strb);
         end
         if (state.aw_addr == comparator_control_pkg::addr_latch_input_select) begin
            next_state.comparator_latch_input_select = merge_byte(state.comparator_latch_input_select,
                                                                  state.w_data, state.w_strb)
                                                       & comparator_control_pkg::mask_latch_input_select;
         end
      end

      // Read channel
      if (s_axi_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = comparator_control_pkg::resp_okay;
         if (s_axi_araddr == comparator_control_pkg::addr_enable_hysteresis) begin
            next_state.rdata = {24'h00_0000, state.comparator_enable_hysteresis};
         end else if (s_axi_araddr == comparator_control_pkg::addr_latch_input_select) begin
            next_state.rdata = {24'h00_0000, state.comparator_latch_input_select};
         end else begin
            next_state.rdata = 32'h0000_0000;
            next_state.rresp = comparator_control_pkg::resp_slverr;
         end
      end else if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end

      // Analog controls follow the registers
      cfg = state.comparator_enable_hysteresis;
      next_state.comp_on = cfg[comparator_control_pkg::on_lsb +: 4];
      next_state.hyst = cfg[comparator_control_pkg::hyst_lsb +: 4];
      next_state.pull_off = cfg[comparator_control_pkg::on_lsb +: 4];
      next_state.neg_shared = state.comparator_latch_input_select[comparator_control_pkg::switch_bit];
      next_state.neg_own = {3{~state.comparator_latch_input_select[comparator_control_pkg::switch_bit]}};

      // Outputs of switched-off comparators read low
      next_state.comp_out = {latched_out, state.sync_raw[1][0]} & state.comp_on;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
         state.comparator_enable_hysteresis <= comparator_control_pkg::reset_enable_hysteresis;
         state.comparator_latch_input_select <= comparator_control_pkg::reset_latch_input_select;
         state.hyst <= 4'hf;
         state.neg_own <= 3'h7;
      end else begin
         state <= next_state;
      end
   end

   assign s_axi_awready = !state.aw_held;
   assign s_axi_wready = !state.w_held;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp = state.bresp;
   assign s_axi_arready = !state.rvalid;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   assign comparator_on = state.comp_on;
   assign hysteresis_enable = state.hyst;
   assign pull_high_disconnect = state.pull_off;
   assign negative_pin_select_own = state.neg_own;
   assign shared_negative_pin_select = state.neg_shared;
   assign comparator_out = state.comp_out;
endmodule : comparator_control_latch

/* File: comparator_control_properties.sv */
// Checker for the comparator control block: bus handshakes and analog controls.
// Bound to comparator_control_latch and sees only its ports.
module comparator_control_properties #(
   parameter int num_comparators = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Comparator side
   input wire logic [3:0] comparator_raw,
   input wire logic [3:0] comparator_on,
   input wire logic [3:0] hysteresis_enable,
   input wire logic [3:0] pull_high_disconnect,
   input wire logic [2:0] negative_pin_select_own,
   input wire logic shared_negative_pin_select,
   input wire logic [3:0] comparator_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_pull_follow: assert property (pull_high_disconnect == comparator_on)
      else $error("pull-high control differs from enable");
   a_neg_route: assert property (negative_pin_select_own == {3{~shared_negative_pin_select}})
      else $error("negative input routing wrong");
   a_off_zero: assert property ((~comparator_on & ~$past(comparator_on) & comparator_out) == 4'h0)
      else $error("output of a disabled comparator is high");
   a_direct_ch0: assert property (comparator_on[0] && $past(comparator_on[0], 3)
      |-> comparator_out[0] == $past(comparator_raw[0], 3))
      else $error("channel 0 output not direct");
   a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not released");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_rdata_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read data bits set");
   a_reset_vals: assert property ($rose(aresetn) |-> hysteresis_enable == 4'hf && comparator_on == 4'h0
      && negative_pin_select_own == 3'h7)
      else $error("analog controls not at power-on values");
endmodule : comparator_control_properties

bind comparator_control_latch comparator_control_properties #(.num_comparators(num_comparators)) props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .comparator_raw(comparator_raw), .comparator_on(comparator_on),
   .hysteresis_enable(hysteresis_enable), .pull_high_disconnect(pull_high_disconnect),
   .negative_pin_select_own(negative_pin_select_own),
   .shared_negative_pin_select(shared_negative_pin_select), .comparator_out(comparator_out));

/* File: comparator_far_side.sv */
// Model of the analog comparator cores.
// Assumes the bench sets the wanted comparison result per channel.
module comparator_far_side (
   // Clock
   input wire logic aclk,
   // Controls
   input wire logic [3:0] comparator_on,
   input wire logic [3:0] level,
   // Core outputs
   output logic [3:0] comparator_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] junk = 4'h0;
   // A core that is off gives no defined output
   always @(posedge aclk) junk <= ~junk;
   assign comparator_raw = (comparator_on & level) | (~comparator_on & junk);
endmodule : comparator_far_side

/* File: tb.sv */
// Bench for the comparator control block over its register bus.
// Assumes the far side model drives the raw comparator outputs.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] awaddr = 0, araddr = 0, level = 0;
   logic [31:0] wdata = 0;
   logic [8:0] src = 0;
   logic awready, wready, bvalid, arready, rvalid, shared;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] raw, on, hyst, pull, cout;
   logic [2:0] own;
   int num_errors = 0, n_compared = 0;
   always #2 aclk = ~aclk;
   comparator_far_side far (.aclk(aclk), .comparator_on(on), .level(level), .comparator_raw(raw));
   comparator_control_latch DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .comparator_raw(raw), .pwm_out_ch0(src[0]), .pwm_out_ch1(src[1]), .pwm_out_ch2(src[2]),
      .phase_a_high_gate(src[3]), .phase_b_high_gate(src[4]), .phase_c_high_gate(src[5]),
      .phase_a_low_gate(src[6]), .phase_b_low_gate(src[7]), .phase_c_low_gate(src[8]),
      .comparator_on(on), .hysteresis_enable(hyst), .pull_high_disconnect(pull),
      .negative_pin_select_own(own), .shared_negative_pin_select(shared), .comparator_out(cout));
   task automatic tally_and_finish;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [1:0] resp(input bit e);
      return e ? comparator_control_pkg::resp_slverr : comparator_control_pkg::resp_okay;
   endfunction : resp
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input bit e);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awready === 1) begin
            aw = 1; awvalid <= 0;
         end
         if (!w && wready === 1) begin
            w = 1; wvalid <= 0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1);
      chk(32'(bresp), 32'(resp(e)));
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input bit e);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (arready !== 1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1);
      chk(rdata, exp);
      chk(32'(rresp), 32'(resp(e)));
      rready <= 0;
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask : settle
   task automatic latch(input int n, input int c);
      int k;
      k = (c == 0) ? 0 : (c - 1) * 3 + n - 1;
      wr(4, 32'(c << (2 * n)), 0);
      level <= 4'hf; src <= 9'(1 << k);
      settle(6); chk(32'(cout[n]), 1);
      src <= 0; settle(6); level <= 0; settle(6);
      chk(32'(cout[n]), (c == 0) ? 0 : 1);
      src <= 9'(1 << k); settle(6); chk(32'(cout[n]), 0);
   endtask : latch
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd(0, 32'h0000_00f0, 0);
      rd(4, 32'h0000_0000, 0);
      rd(8, 32'h0000_0000, 1);
      wr(8, 32'h0000_0001, 1);
      wr(0, 32'h0000_005a, 0);
      rd(0, 32'h0000_005a, 0);
      settle(2);
      chk(32'(hyst), 32'h0000_0005);
      chk(32'(on), 32'h0000_000a);
      chk(32'(pull), 32'h0000_000a);
      wr(4, 32'h0000_00ff, 0);
      rd(4, 32'h0000_00fe, 0);
      chk(32'({shared, own}), 32'h0000_0008);
      wr(4, 32'h0000_0000, 0);
      settle(2);
      chk(32'({shared, own}), 32'h0000_0007);
      wr(0, 32'h0000_000f, 0);
      for (int n = 1; n < 4; n++) for (int c = 0; c < 4; c++) latch(n, c);
      level <= 4'hf;
      wr(0, 32'h0000_00f0, 0);
      settle(6);
      chk(32'(on), 32'h0000_0000);
      chk(32'(cout), 32'h0000_0000);
      @(posedge aclk);
      aresetn <= 0;
      settle(2);
      aresetn <= 1;
      rd(0, 32'h0000_00f0, 0);
      tally_and_finish;
   end
   initial begin
      #40000;
      num_errors++;
      tally_and_finish;
   end
endmodule : tb
